// ---- flm_ctrl.sv ----
// control, quality and event registers of the feedback link master
//
// Chosen here: the address-and-strobe port.
module flm_ctrl
	import flm_pkg::*;
#(
	parameter int POS_W   = 40,            // position width
	parameter int TMO_CYC = SHORT_TMO_CYC  // short message retry timeout
) (
	input  wire logic             clk,          // 40 MHz clock
	input  wire logic             arst_n,       // async reset
	input  wire flm_bus_req_t     bus_req,      // register access
	output logic [7:0]            bus_rdata,    // read data, next cycle
	input  wire flm_qual_ev_t     qual_ev,      // quality event pulses
	input  wire flm_cond_t        cond,         // event condition levels
	input  wire logic             link_up,      // link established
	input  wire logic             sync_pin,     // sync input pin
	input  wire logic             reset_pin,    // protocol reset pin
	input  wire logic             frame_tick,   // one pulse per frame
	input  wire logic             pos_rx,       // position received pulse
	input  wire logic             safe_rx,      // safe position received
	input  wire logic [POS_W-1:0] rx_safe_pos,  // received safe position
	input  wire logic [POS_W-1:0] rx_fast_pos,  // received fast position
	input  wire logic [POS_W-1:0] est_fast_pos, // estimator position
	input  wire logic             long_launch,  // long message sent
	input  wire logic             long_answer,  // long answer received
	input  wire logic             short_launch, // short message sent
	input  wire logic             short_answer, // short answer received
	input  wire logic [7:0]       pipe_status,  // pipe status from fifo
	input  wire logic [7:0]       pipe_data,    // pipe data from fifo
	input  wire logic             line_tx,      // serial bit to encoder
	output logic                  line_out,     // cable data out
	output logic                  line_oe,      // cable driven
	output logic                  proto_hold,   // protocol held in reset
	output logic                  link_start,   // start-up pulse
	output logic                  msg_reset,    // parameter channel reset
	output logic                  fifo_clear,   // fifo held empty
	output logic                  serial_pipe,  // pipe via serial port
	output logic                  short_retry,  // short message retry
	output logic                  sample_req,   // position sample request
	output logic                  pos_ready,    // position ready pulse
	output logic [POS_W-1:0]      safe_pos,     // safe position out
	output logic [POS_W-1:0]      fast_pos,     // fast position out
	output logic                  irq           // interrupt output
);
	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0] ctrl_r;
	logic [7:0] sync_cnt_r;
	logic [3:0] qm_r;
	logic [3:0] qm_nxt;
	logic [7:0] ev_hi_r;
	logic [7:0] ev_lo_r;
	logic [7:0] mask_hi_r;
	logic [7:0] mask_lo_r;
	logic [7:0] digest_r;
	logic       long_free_r;
	logic       short_free_r;
	logic [12:0] tmo_r;
	logic       sync_s;
	logic       sync_d_r;
	logic       rst_s;
	logic       rst_d_r;
	logic       restart_d_r;
	logic       qm_force;
	logic       sync_evt;
	logic       armed_r;
	logic [7:0] samp_r;
	logic [6:0] cond_d_r;
	logic [7:0] set_hi;
	logic [7:0] set_lo;
	logic       remote_alert;
	logic       restart_evt;
	logic       qm_low;

	flm_sync2 u_sync_pin (
		.clk   (clk),
		.arst_n(arst_n),
		.d_in  (sync_pin),
		.q_out (sync_s)
	);
	flm_sync2 u_rst_pin (
		.clk   (clk),
		.arst_n(arst_n),
		.d_in  (reset_pin),
		.q_out (rst_s)
	);

	// ****************************************************************
	// control registers, host writes only
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r     <= RST_CTRL;
			sync_cnt_r <= RST_SYNC;
			mask_hi_r  <= 8'h00;
			mask_lo_r  <= 8'h00;
			digest_r   <= 8'h00;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				ADR_SYSTEM_CONTROL:  ctrl_r     <= bus_req.wdata;
				ADR_SYNC_CTRL: sync_cnt_r <= bus_req.wdata;
				ADR_MASK_HIGH: mask_hi_r  <= bus_req.wdata & MASK_HIGH_VALID;
				ADR_MASK_LOW:  mask_lo_r  <= bus_req.wdata & MASK_LOW_VALID;
				ADR_DIGEST:    digest_r   <= bus_req.wdata;
				default: ;
			endcase
		end
	end

	assign line_out    = line_tx;
	assign line_oe     = ctrl_r[CB_DRIVE];
	assign msg_reset   = ctrl_r[CB_MSG_RST];
	assign fifo_clear  = ctrl_r[CB_FIFO_CLR];
	assign serial_pipe = ctrl_r[CB_SPIPE];

	// ****************************************************************
	// protocol restart
	// ****************************************************************
	// counter at zero forces the same restart path as the host bit
	assign qm_force    = (qm_r == 4'h0);
	assign restart_evt = (ctrl_r[CB_RESTART] & ~restart_d_r)
		| (rst_s & ~rst_d_r) | qm_force;
	assign proto_hold  = ctrl_r[CB_RESTART] | rst_s;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			restart_d_r <= 1'b0;
			rst_d_r     <= 1'b0;
			link_start  <= 1'b0;
		end else begin
			restart_d_r <= ctrl_r[CB_RESTART];
			rst_d_r     <= rst_s;
			link_start  <= (restart_d_r & ~ctrl_r[CB_RESTART])
				| (rst_d_r & ~rst_s) | qm_force;
		end
	end

	// ****************************************************************
	// sync edge, sampling and position ready
	// ****************************************************************
	assign sync_evt = ctrl_r[CB_EDGE] ? (~sync_s & sync_d_r)
		: (sync_s & ~sync_d_r);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_d_r   <= 1'b0;
			samp_r     <= 8'h00;
			sample_req <= 1'b0;
		end else begin
			sync_d_r <= sync_s;
			if (sync_evt)
				samp_r <= 8'h00;
			else if (frame_tick && samp_r < sync_cnt_r)
				samp_r <= samp_r + 8'h01;
			// zero count means every frame samples
			sample_req <= frame_tick && (sync_cnt_r == 8'h00
				|| (samp_r < sync_cnt_r && !sync_evt));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			armed_r   <= 1'b0;
			pos_ready <= 1'b0;
		end else begin
			if (sync_evt)
				armed_r <= 1'b1;
			else if (pos_rx)
				armed_r <= 1'b0;
			pos_ready <= pos_rx && (ctrl_r[CB_RDY_ALL] || armed_r);
		end
	end

	// ****************************************************************
	// quality counter
	// ****************************************************************
	always_comb begin
		logic [5:0] dec;
		logic [6:0] inc;
		dec = 6'h00;
		inc = {3'b000, qm_r};
		if (qual_ev.sync_err_last)  dec = dec + PEN_SYNC_LAST;
		if (qual_ev.sync_err_first) dec = dec + PEN_SYNC_FIRST;
		if (qual_ev.rssi_low)       dec = dec + PEN_RSSI;
		if (qual_ev.pc_code_err)    dec = dec + PEN_PC_CODE;
		if (qual_ev.proc_code_err)  dec = dec + PEN_PROC_CODE;
		if (qual_ev.unk_char)       dec = dec + PEN_UNK_CHAR;
		if (qual_ev.sc1_err)        dec = dec + PEN_SC1;
		if (qual_ev.sc2_err)        dec = dec + PEN_SC2;
		inc = inc + {6'h00, qual_ev.sync_ok}
			+ {6'h00, qual_ev.crc_ok};
		if (inc < {1'b0, dec})
			qm_nxt = 4'h0;
		else if (inc - {1'b0, dec} > {3'b000, QM_MAX})
			qm_nxt = QM_MAX;
		else
			qm_nxt = 4'(inc - {1'b0, dec});
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			qm_r <= QM_INIT;
		else if (qm_force || proto_hold)
			qm_r <= QM_INIT;
		else
			qm_r <= qm_nxt;
	end

	assign qm_low = (qm_r < QM_LOW);

	// ****************************************************************
	// event flags
	// ****************************************************************
	assign remote_alert = |(cond.remote_summary & digest_r);
	// edge flags look at the rising edge of their condition only
	always_comb begin
		set_hi = 8'h00;
		set_lo = 8'h00;
		set_hi[6] = remote_alert;
		set_hi[5] = cond.safe_channel_error & ~cond_d_r[0];
		set_hi[3] = cond.fast_pos_err & ~cond_d_r[1];
		set_hi[2] = cond.safe_angle_error & ~cond_d_r[2];
		set_hi[1] = cond.deviation_err & ~cond_d_r[3];
		set_hi[0] = restart_evt;
		set_lo[5] = cond.msg_init_ack;
		set_lo[4] = cond.long_reply_error & ~cond_d_r[4];
		set_lo[2] = qm_low;
		set_lo[1] = long_free_r & ~cond_d_r[5];
		set_lo[0] = short_free_r & ~cond_d_r[6];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cond_d_r <= 7'h60; // free flags idle high: no edge after reset
			ev_hi_r  <= 8'h00;
			ev_lo_r  <= 8'h00;
		end else begin
			cond_d_r <= {short_free_r, long_free_r, cond.long_reply_error,
				cond.deviation_err, cond.safe_angle_error,
				cond.fast_pos_err, cond.safe_channel_error};
			// write one clears; a set in the same cycle wins
			if (bus_req.wr && bus_req.addr == ADR_EV_HIGH)
				ev_hi_r <= (ev_hi_r & ~bus_req.wdata) | set_hi;
			else
				ev_hi_r <= ev_hi_r | set_hi;
			if (bus_req.wr && bus_req.addr == ADR_EV_LOW)
				ev_lo_r <= (ev_lo_r & ~bus_req.wdata) | set_lo;
			else
				ev_lo_r <= ev_lo_r | set_lo;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(ev_hi_r[6:0] & mask_hi_r[6:0])
				| |(ev_lo_r & mask_lo_r);
	end

	// ****************************************************************
	// message channel state
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			long_free_r  <= 1'b1;
			short_free_r <= 1'b1;
			tmo_r        <= 13'h0000;
			short_retry  <= 1'b0;
		end else begin
			short_retry <= 1'b0;
			if (msg_reset || long_answer)
				long_free_r <= 1'b1;
			else if (long_launch)
				long_free_r <= 1'b0;
			if (msg_reset || short_answer) begin
				short_free_r <= 1'b1;
				tmo_r        <= 13'h0000;
			end else if (short_launch) begin
				short_free_r <= 1'b0;
				tmo_r        <= 13'h0000;
			end else if (!short_free_r) begin
				// no answer yet: resend and restart the wait
				if (tmo_r == 13'(TMO_CYC - 1)) begin
					tmo_r       <= 13'h0000;
					short_retry <= 1'b1;
				end else
					tmo_r <= tmo_r + 13'h0001;
			end
		end
	end

	// ****************************************************************
	// position outputs
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			safe_pos <= '0;
			fast_pos <= '0;
		end else begin
			if (cond.safe_angle_error)
				safe_pos <= {(POS_W/8){ERR_BYTE}};
			else if (safe_rx && !cond.safe_channel_error)
				safe_pos <= rx_safe_pos;
			if (cond.safe_angle_error)
				fast_pos <= {(POS_W/8){ERR_BYTE}};
			else if (cond.fast_pos_err)
				fast_pos <= est_fast_pos;
			else if (pos_rx)
				fast_pos <= rx_fast_pos;
		end
	end

	// ****************************************************************
	// register read
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			bus_rdata <= 8'h00;
		else if (bus_req.rd) begin
			case (bus_req.addr)
				ADR_SYSTEM_CONTROL:  bus_rdata <= ctrl_r;
				ADR_QUALITY:   bus_rdata <= {link_up, 3'b000, qm_r};
				ADR_EV_HIGH:   bus_rdata <= {irq, ev_hi_r[6:0]};
				ADR_EV_LOW:    bus_rdata <= ev_lo_r;
				ADR_MASK_HIGH: bus_rdata <= mask_hi_r;
				ADR_MASK_LOW:  bus_rdata <= mask_lo_r;
				ADR_DIGEST:    bus_rdata <= digest_r;
				ADR_PIPE_STAT: bus_rdata <= serial_pipe ? 8'h00 : pipe_status;
				ADR_PIPE_DATA: bus_rdata <= serial_pipe ? 8'h00 : pipe_data;
				default:       bus_rdata <= 8'h00;
			endcase
		end else
			bus_rdata <= 8'h00;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_zero_qm;
		qm_r == 4'h0;
	endsequence
	sequence s_back_to_init;
		qm_r == QM_INIT && ev_hi_r[0] && link_start;
	endsequence

	AST_QM_ZERO_RESTART: assert property (
		s_zero_qm |=> s_back_to_init)
		else $error("zero quality did not restart the link");
	AST_QM_LOW_WARN: assert property (
		qm_r < 4'he |=> ev_lo_r[2])
		else $error("low quality warning missing");
	AST_QM_SATURATE: assert property (
		qm_r == 4'hf && !proto_hold && qual_ev == flm_qual_ev_t'(10'h003)
		|=> qm_r == 4'hf)
		else $error("quality counter passed fifteen");
	AST_CTRL_HOST_ONLY: assert property (
		!(bus_req.wr && bus_req.addr == ADR_SYSTEM_CONTROL) |=> $stable(ctrl_r))
		else $error("control bits changed without a host write");
	AST_PIPE_ZERO: assert property (
		bus_req.rd && serial_pipe && bus_req.addr == ADR_PIPE_DATA
		|=> bus_rdata == 8'h00)
		else $error("pipe register not zero with serial pipe on");
	AST_LONG_BUSY: assert property (
		long_launch && !long_answer && !msg_reset
		##1 (!long_answer && !msg_reset)[*2] |-> !long_free_r)
		else $error("long channel free before answer");
	AST_SET_WINS: assert property (
		bus_req.wr && bus_req.addr == ADR_EV_LOW && set_lo[4]
		|=> ev_lo_r[4])
		else $error("event lost to simultaneous clear");
	AST_SENSOR_PATTERN: assert property (
		cond.safe_angle_error |=> safe_pos == {(POS_W/8){ERR_BYTE}}
		&& fast_pos == {(POS_W/8){ERR_BYTE}})
		else $error("sensor error pattern not shown");
	AST_SAFE_HOLD: assert property (
		cond.safe_channel_error && !cond.safe_angle_error |=> $stable(safe_pos))
		else $error("safe position changed on channel error");
	AST_READY_SYNC_ONLY: assert property (
		pos_ready && !$past(ctrl_r[CB_RDY_ALL]) |-> $past(armed_r))
		else $error("position ready without a sync");
endmodule

// ---- flm_enc_model.sv ----
// encoder-side model of the cable partner for the link master control bench
module flm_enc_model
	import flm_pkg::*;
(
	input  wire logic         clk,     // system clock
	input  wire logic         arst_n,  // async reset
	input  wire logic         line_oe, // cable driven by master
	input  wire logic         hold,    // protocol held in reset
	input  wire flm_qual_ev_t ev_req,  // event to report, one cycle
	output logic              link_up, // link established
	output flm_qual_ev_t      qual_ev  // quality event pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] up_cnt_r;
	// a floating cable carries nothing, so no events reach the master
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			qual_ev <= '0;
		end else begin
			qual_ev <= line_oe ? ev_req : '0;
		end
	end
	// link comes up a few cycles after the cable is driven
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			up_cnt_r <= 2'h0;
		end else if (!line_oe || hold) begin
			up_cnt_r <= 2'h0;
		end else if (up_cnt_r != 2'h3) begin
			up_cnt_r <= up_cnt_r + 2'h1;
		end
	end
	assign link_up = (up_cnt_r == 2'h3);
endmodule

// ---- flm_pkg.sv ----
// constants, bus carriers and register layout of the feedback link master control
// Operation
// - restart bit high holds link protocol in reset; clearing it starts a new link
// - message channel reset bit resets parameter channel, drops running messages
// - pipe fifo clear bit keeps fifo empty, nothing stored or read
// - ready-all mode flags every position, otherwise only the first position after each sync
// - serial pipe enable routes pipe to serial port, pipe registers read zero
// - sync edge select picks trailing edge when one, leading edge when zero
// - line drive enable drives cable toward encoder, else cable floats
// - control bits reset to zero and change only by host writes
// - sample count zero runs free, nonzero takes that many samples per sync
// - quality penalties per error kind as listed in the quality table
// - quality gains one per good safe sync and per good safe crc
// - quality starts at eight, tops at fifteen, zero forces protocol reset
// - quality below fourteen raises low-quality warning
// - quality register read-only: link bit, three zero bits, counter nibble
// - master only sets event flags; host clears them
// - edge flags set on new condition only; level flags set while condition holds
// - remote alert is level, gated by digest mask; int bit mirrors interrupt
// - safe channel error keeps last safe position, fast position untouched
// - fast position error substitutes estimator value
// - sensor error shows FD bytes for safe and fast position
// - protocol reset flag set on host, quality or reset-input restart
// - event flag reaches interrupt only when its mask bit is set
package flm_pkg;
	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] ADR_SYSTEM_CONTROL  = 8'h00;
	localparam logic [7:0] ADR_SYNC_CTRL = 8'h01;
	localparam logic [7:0] ADR_QUALITY   = 8'h03;
	localparam logic [7:0] ADR_EV_HIGH   = 8'h04;
	localparam logic [7:0] ADR_EV_LOW    = 8'h05;
	localparam logic [7:0] ADR_MASK_HIGH = 8'h06;
	localparam logic [7:0] ADR_MASK_LOW  = 8'h07;
	localparam logic [7:0] ADR_DIGEST    = 8'h08;
	localparam logic [7:0] ADR_PIPE_STAT = 8'h2d;
	localparam logic [7:0] ADR_PIPE_DATA = 8'h2e;
	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int CB_RESTART  = 7;
	localparam int CB_MSG_RST  = 6;
	localparam int CB_FIFO_CLR = 5;
	localparam int CB_RDY_ALL  = 3;
	localparam int CB_SPIPE    = 2;
	localparam int CB_EDGE     = 1;
	localparam int CB_DRIVE    = 0;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_SYNC  = 8'h01;
	localparam logic [7:0] MASK_HIGH_VALID = 8'h6f;
	localparam logic [7:0] MASK_LOW_VALID  = 8'h37;
	localparam logic [7:0] ERR_BYTE  = 8'hfd;
	// ****************************************************************
	// quality counter
	// ****************************************************************
	localparam logic [3:0] QM_INIT = 4'h8;
	localparam logic [3:0] QM_MAX  = 4'hf;
	localparam logic [3:0] QM_LOW  = 4'he;
	localparam logic [5:0] PEN_SYNC_LAST  = 6'h04;
	localparam logic [5:0] PEN_SYNC_FIRST = 6'h06;
	localparam logic [5:0] PEN_RSSI       = 6'h04;
	localparam logic [5:0] PEN_PC_CODE    = 6'h01;
	localparam logic [5:0] PEN_PROC_CODE  = 6'h02;
	localparam logic [5:0] PEN_UNK_CHAR   = 6'h02;
	localparam logic [5:0] PEN_SC1        = 6'h06;
	localparam logic [5:0] PEN_SC2        = 6'h08;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ        = 40;
	localparam int SHORT_TMO_US   = 100;
	localparam int SHORT_TMO_CYC  = SHORT_TMO_US * CLK_MHZ;
	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} flm_bus_req_t;
	typedef struct packed {
		logic sync_err_last;
		logic sync_err_first;
		logic rssi_low;
		logic pc_code_err;
		logic proc_code_err;
		logic unk_char;
		logic sc1_err;
		logic sc2_err;
		logic sync_ok;
		logic crc_ok;
	} flm_qual_ev_t;
	typedef struct packed {
		logic safe_channel_error;
		logic deviation_err;
		logic safe_angle_error;
		logic fast_pos_err;
		logic msg_init_ack;
		logic long_reply_error;
		logic [7:0] remote_summary;
	} flm_cond_t;
endpackage

// ---- flm_sync2.sv ----
// two-flop synchroniser for pins entering the clock domain
module flm_sync2 (
	input  wire logic clk,    // system clock
	input  wire logic arst_n, // async reset
	input  wire logic d_in,   // asynchronous level
	output logic      q_out   // synchronised level
);
	logic meta_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule

// ---- test_flm_ctrl.sv ----
// self-checking bench of the feedback link master control registers
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_flm_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import flm_pkg::*;
	logic clk, arst_n, link_up, sync_pin, reset_pin, frame_tick;
	logic pos_rx, safe_rx, line_tx, hold, drive, start, samp, rdy, irq;
	logic msg_rst, fclr, spipe, lout, retry, l_go, l_ans, s_go, s_ans;
	logic [39:0] sp, fp, ep, spos, fpos;
	logic [7:0]  rdata, pstat, pdata;
	flm_bus_req_t req;
	flm_qual_ev_t ev_req, qual_ev;
	flm_cond_t    cond;
	int err_count, tests_run;
	// ****************************************************************
	// design and partner
	// ****************************************************************
	flm_ctrl #(.POS_W(40), .TMO_CYC(8)) dut_u (.clk(clk), .arst_n(arst_n),
		.bus_req(req), .bus_rdata(rdata), .qual_ev(qual_ev), .cond(cond),
		.link_up(link_up), .sync_pin(sync_pin), .reset_pin(reset_pin),
		.frame_tick(frame_tick), .pos_rx(pos_rx), .safe_rx(safe_rx),
		.rx_safe_pos(sp), .rx_fast_pos(fp), .est_fast_pos(ep),
		.long_launch(l_go), .long_answer(l_ans), .short_launch(s_go),
		.short_answer(s_ans), .pipe_status(pstat), .pipe_data(pdata),
		.line_tx(line_tx), .line_out(lout), .line_oe(drive),
		.proto_hold(hold), .link_start(start), .msg_reset(msg_rst),
		.fifo_clear(fclr), .serial_pipe(spipe), .short_retry(retry),
		.sample_req(samp), .pos_ready(rdy), .safe_pos(spos),
		.fast_pos(fpos), .irq(irq));
	flm_enc_model enc_u (.clk(clk), .arst_n(arst_n), .line_oe(drive),
		.hold(hold), .ev_req(ev_req), .link_up(link_up), .qual_ev(qual_ev));
	// ****************************************************************
	// bus and event tasks
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '0;
		#1 `CHK(rdata, exp)
	endtask
	task automatic ev(input flm_qual_ev_t e);
		@(posedge clk) ev_req <= e;
		@(posedge clk) ev_req <= '0;
		repeat (2) @(posedge clk);
	endtask
	// bounded wait for the start-up pulse
	task automatic wait_start();
		int n;
		n = 0;
		while (start !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(start, 1'b1)
	endtask
	// one frame tick, then the sample request it should give
	task automatic tick(input logic exp);
		@(posedge clk) frame_tick <= 1'b1;
		@(posedge clk) frame_tick <= 1'b0;
		#1 `CHK(samp, exp)
	endtask
	// sync pin to a level, let it through the synchroniser, then a position
	task automatic pulse_pos(input logic s, input logic exp);
		@(posedge clk) sync_pin <= s;
		repeat (3) @(posedge clk);
		@(posedge clk) pos_rx <= 1'b1;
		@(posedge clk) pos_rx <= 1'b0;
		#1 `CHK(rdy, exp)
	endtask
	task automatic results();
		$display("checks=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic sc_reset();
		rd(ADR_SYSTEM_CONTROL, 8'h00);
		rd(ADR_SYNC_CTRL, 8'h00);
		rd(ADR_QUALITY, 8'h08);
		rd(ADR_EV_HIGH, 8'h00);
		rd(8'h3f, 8'h00);
	endtask
	task automatic sc_ctrl();
		wr(ADR_SYSTEM_CONTROL, 8'h65);
		#1 `CHK({msg_rst, fclr, spipe, drive}, 4'hf)
		rd(ADR_SYSTEM_CONTROL, 8'h65);
		rd(ADR_PIPE_STAT, 8'h00);
		rd(ADR_PIPE_DATA, 8'h00);
		wr(ADR_SYSTEM_CONTROL, 8'h01);
		rd(ADR_PIPE_STAT, 8'h5a);
		rd(ADR_PIPE_DATA, 8'h3c);
		`CHK({msg_rst, fclr, spipe, drive}, 4'h1)
		@(posedge clk) line_tx <= 1'b1;
		#1 `CHK(lout, 1'b1)
	endtask
	task automatic sc_quality();
		for (int i = 0; i < 9; i++) ev(10'h003);
		rd(ADR_QUALITY, 8'h8f);
		wr(ADR_EV_LOW, 8'hff);
		wr(ADR_EV_HIGH, 8'hff);
		rd(ADR_EV_LOW, 8'h00);
		ev(10'h001);
		rd(ADR_QUALITY, 8'h8f);
		ev(10'h004);
		rd(ADR_QUALITY, 8'h87);
		rd(ADR_EV_LOW, 8'h04);
		ev(10'h200);
		fork
			ev(10'h100);
			wait_start();
		join
		rd(ADR_QUALITY, 8'h88);
		rd(ADR_EV_HIGH, 8'h01);
		rd(ADR_SYSTEM_CONTROL, 8'h01);
		ev(10'h040);
		rd(ADR_QUALITY, 8'h87);
	endtask
	task automatic sc_irq();
		wr(ADR_MASK_HIGH, 8'h01);
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b1)
		rd(ADR_EV_HIGH, 8'h81);
		wr(ADR_MASK_HIGH, 8'h00);
		wr(ADR_EV_HIGH, 8'h01);
		rd(ADR_EV_HIGH, 8'h00);
		`CHK(irq, 1'b0)
	endtask
	task automatic sc_restart();
		wr(ADR_SYSTEM_CONTROL, 8'h81);
		#1 `CHK(hold, 1'b1)
		fork
			wr(ADR_SYSTEM_CONTROL, 8'h01);
			wait_start();
		join
		rd(ADR_EV_HIGH, 8'h01);
		wr(ADR_EV_HIGH, 8'h01);
		@(posedge clk) reset_pin <= 1'b1;
		repeat (4) @(posedge clk);
		#1 `CHK(hold, 1'b1)
		fork
			@(posedge clk) reset_pin <= 1'b0;
			wait_start();
		join
		rd(ADR_EV_HIGH, 8'h01);
	endtask
	task automatic sc_msg();
		@(posedge clk) {l_go, s_go} <= 2'b11;
		@(posedge clk) {l_go, s_go} <= 2'b00;
		repeat (7) @(posedge clk);
		#1 `CHK(retry, 1'b0)
		@(posedge clk);
		#1 `CHK(retry, 1'b1)
		rd(ADR_EV_LOW, 8'h04);
		@(posedge clk) l_ans <= 1'b1;
		@(posedge clk) l_ans <= 1'b0;
		rd(ADR_EV_LOW, 8'h06);
		@(posedge clk) s_ans <= 1'b1;
		@(posedge clk) s_ans <= 1'b0;
		rd(ADR_EV_LOW, 8'h07);
		@(posedge clk) {l_go, s_go} <= 2'b11;
		@(posedge clk) {l_go, s_go} <= 2'b00;
		wr(ADR_EV_LOW, 8'h03);
		wr(ADR_SYSTEM_CONTROL, 8'h41);
		wr(ADR_SYSTEM_CONTROL, 8'h01);
		rd(ADR_EV_LOW, 8'h07);
		// clear and a new edge condition in the same cycle
		@(posedge clk) begin
			req <= '{1'b1, 1'b0, ADR_EV_LOW, 8'hff};
			cond.long_reply_error <= 1'b1;
		end
		@(posedge clk) req <= '0;
		rd(ADR_EV_LOW, 8'h14);
		wr(ADR_EV_LOW, 8'hff);
		rd(ADR_EV_LOW, 8'h04);
		cond.long_reply_error <= 1'b0;
	endtask
	task automatic sc_sync();
		wr(ADR_SYNC_CTRL, 8'h00);
		tick(1'b1);
		wr(ADR_SYNC_CTRL, 8'h01);
		tick(1'b1);
		tick(1'b0);
		pulse_pos(1'b1, 1'b1);
		tick(1'b1);
		pulse_pos(1'b1, 1'b0);
		wr(ADR_SYSTEM_CONTROL, 8'h03);
		pulse_pos(1'b0, 1'b1);
		pulse_pos(1'b1, 1'b0);
		wr(ADR_SYSTEM_CONTROL, 8'h09);
		pulse_pos(1'b1, 1'b1);
		wr(ADR_SYSTEM_CONTROL, 8'h01);
	endtask
	task automatic sc_pos();
		@(posedge clk) begin
			sp <= 40'h1122334455;
			fp <= 40'h0a0b0c0d0e;
			ep <= 40'h0102030405;
			{safe_rx, pos_rx} <= 2'b11;
		end
		@(posedge clk) begin
			{cond.safe_channel_error, cond.fast_pos_err} <= 2'b11;
			sp <= 40'h9999999999;
		end
		#1 `CHK({spos, fpos}, {40'h1122334455, 40'h0a0b0c0d0e})
		@(posedge clk) cond.safe_angle_error <= 1'b1;
		#1 `CHK(spos, 40'h1122334455)
		`CHK(fpos, 40'h0102030405)
		@(posedge clk) {cond, safe_rx, pos_rx} <= '0;
		#1 `CHK({spos, fpos}, {10{8'hfd}})
	endtask
	// ****************************************************************
	// clock, reset and main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		arst_n = 1'b0;
		req = '0;
		ev_req = '0;
		cond = '0;
		{sp, fp, ep} = '0;
		{sync_pin, reset_pin, frame_tick, pos_rx, safe_rx, line_tx} = '0;
		{l_go, l_ans, s_go, s_ans} = '0;
		pstat = 8'h5a;
		pdata = 8'h3c;
		err_count = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		sc_reset();
		sc_ctrl();
		sc_quality();
		sc_irq();
		sc_restart();
		sc_msg();
		sc_sync();
		sc_pos();
		results();
	end
	initial begin
		#200us;
		err_count++;
		results();
	end
endmodule
